// ==== core/startup_seq_pkg.sv ====
// ==========================================================================
// start-up sequencer shared constants
package startup_seq_pkg;

	// ======================================================================
	// timing
	localparam int unsigned CLK_FREQ_KHZ = 200000;
	localparam int unsigned POWERUP_TIMER_TIME_MS = 64;
	localparam int unsigned POWERUP_TIMER_CYCLES_DEF = POWERUP_TIMER_TIME_MS * CLK_FREQ_KHZ;
	localparam int unsigned OST_OSC_COUNT = 1024;
	localparam int unsigned OST_W = 11;
	localparam logic [3:0] MASTER_CLEAR_PIN_RELEASE_CYCLES = 4'hA;
	localparam int unsigned CLKOUT_DIV_W = 2;

	// ======================================================================
	// register map, byte addresses
	localparam int unsigned AXI_ADDR_W = 4;
	localparam logic [1:0] IDX_CFG = 2'h0;
	localparam logic [1:0] IDX_CLKSW = 2'h1;
	localparam logic [1:0] IDX_STATUS = 2'h2;
	localparam logic [1:0] IDX_NONE = 2'h3;
	localparam logic [AXI_ADDR_W-1:0] OFS_CFG = 4'h0;
	localparam logic [AXI_ADDR_W-1:0] OFS_CLKSW = 4'h4;
	localparam logic [AXI_ADDR_W-1:0] OFS_STATUS = 4'h8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ======================================================================
	// configuration register fields
	localparam int unsigned CFG_POWERUP_DELAY_SELECT_LSB = 0;
	localparam int unsigned CFG_POWERUP_DELAY_SELECT_W = 2;
	localparam int unsigned CFG_RCSS_LSB = 2;
	localparam int unsigned CFG_CLKOUT_BIT = 5;
	localparam int unsigned CFG_MCLRE_BIT = 6;
	localparam int unsigned CFG_GPIO_D_BIT = 7;
	localparam int unsigned CFG_GPIO_OE_BIT = 8;
	localparam logic [15:0] CFG_MASK = 16'h01FF;
	localparam logic [15:0] CFG_RESET = 16'h0059;

	// ======================================================================
	// clock switch register and status register fields
	localparam int unsigned CSW_NEW_CLOCK_SOURCE_SELECT_LSB = 0;
	localparam int unsigned CSW_NEW_CLOCK_DIVIDER_LSB = 4;
	localparam int unsigned STAT_ST_LSB = 0;
	localparam int unsigned STAT_POWERUP_TIMER_BIT = 4;
	localparam int unsigned STAT_OST_BIT = 5;
	localparam int unsigned STAT_MASTER_CLEAR_PIN_BIT = 6;
	localparam int unsigned STAT_BUSY_BIT = 7;
	localparam int unsigned STAT_SRC_LSB = 8;
	localparam int unsigned STAT_DIV_LSB = 12;
	localparam int unsigned STAT_PIN_BIT = 16;

	// ======================================================================
	// clock sources, amplifier gain and external clock power codes
	localparam int unsigned SRC_W = 3;
	localparam int unsigned DIV_W = 4;
	localparam logic [2:0] SRC_EXT_HIGH = 3'h0;
	localparam logic [2:0] SRC_EXT_MED = 3'h1;
	localparam logic [2:0] SRC_EXT_LOW = 3'h2;
	localparam logic [2:0] SRC_XTAL_LOW = 3'h3;
	localparam logic [2:0] SRC_XTAL_MED = 3'h4;
	localparam logic [2:0] SRC_XTAL_HIGH = 3'h5;
	localparam logic [2:0] SRC_INTERNAL = 3'h6;
	localparam logic [1:0] LVL_OFF = 2'h0;
	localparam logic [1:0] LVL_LOW = 2'h1;
	localparam logic [1:0] LVL_MED = 2'h2;
	localparam logic [1:0] LVL_HIGH = 2'h3;

	// ======================================================================
	// sequencer states
	typedef enum logic [3:0] {
		ST_HOLD = 4'h1,
		ST_WAIT = 4'h2,
		ST_DELAY = 4'h4,
		ST_RUN = 4'h8
	} seq_st_t;

endpackage : startup_seq_pkg

// ==== core/startup_count_timer.sv ====
`timescale 1ns/1ps
// ==========================================================================
// event counter that flags done once limit ticks have been seen
module startup_count_timer #(
	parameter int WIDTH = 11
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic clear,
	input wire logic tick,
	input wire logic [WIDTH-1:0] limit,
	output logic done
);
	import startup_seq_pkg::*;

	typedef struct packed {
		logic [WIDTH-1:0] cnt;
		logic done;
	} tmr_state_t;

	tmr_state_t s_q;
	tmr_state_t s_d;

	// count stops at the limit so done stays a level until cleared
	always_comb begin
		s_d = s_q;
		if (!rst_n || clear) begin
			s_d = '0;
		end else if (tick && !s_q.done) begin
			s_d.cnt = s_q.cnt + WIDTH'(1);
			if (s_q.cnt + WIDTH'(1) == limit) begin
				s_d.done = 1'b1;
			end
		end
	end

	// frozen while ce is low, so a stopped clock loses nothing
	always_ff @(posedge clk) begin
		if (!rst_n || ce) begin
			s_q <= s_d;
		end
	end

	assign done = s_q.done;

endmodule : startup_count_timer

// ==== core/startup_reset_clock_sequencer.sv ====
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
// Operation
// - power-up timer gives 64 ms after release
// - core held in reset while power-up timer counts
// - power-up timer only with non-zero delay select
// - power-up timer starts after power-on and brown-out release
// - run needs both timers done, master clear released
// - timers run regardless of master clear pin
// - run starts 10 cycles after master clear rises
// - reset source select; run-time writes switch clock
// - external clock in; clock out pin or GPIO
// - three external clock power settings by configuration
// - external clock mode skips oscillator start-up timer
// - fully static: stopped clock keeps all state
// - crystal mode selects amplifier gain low/medium/high
// - crystal modes count 1024 oscillations after start
module startup_reset_clock_sequencer #(
	parameter int unsigned POWERUP_TIMER_CYCLES = startup_seq_pkg::POWERUP_TIMER_CYCLES_DEF
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CE,
	input wire logic POR_ACTIVE,
	input wire logic BOR_ACTIVE,
	input wire logic MASTER_CLEAR_PIN_N,
	input wire logic CLOCK_IN_PIN,
	input wire logic WAKE,
	input wire logic CLOCK_OUT_PIN_I,
	output logic CLOCK_OUT_PIN_O,
	output logic CLOCK_OUT_PIN_OE_N,
	output logic CORE_RESET_N,
	output logic CORE_CLK_EN,
	output logic OSC_NOT_READY,
	output logic [startup_seq_pkg::SRC_W-1:0] SYS_CLK_SRC,
	output logic [startup_seq_pkg::DIV_W-1:0] SYS_CLK_DIV,
	output logic [1:0] AMP_GAIN,
	output logic [1:0] EXT_CLK_POWER,
	input wire logic [startup_seq_pkg::AXI_ADDR_W-1:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [startup_seq_pkg::AXI_ADDR_W-1:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY
);
	import startup_seq_pkg::*;

	localparam int unsigned POWERUP_TIMER_W = $clog2(POWERUP_TIMER_CYCLES + 1);

	// ======================================================================
	// state
	typedef struct packed {
		seq_st_t st;
		logic [3:0] dly_cnt;
		logic master_clear_pin_meta;
		logic master_clear_pin_sync;
		logic clkin_q;
		logic [15:0] cfg;
		logic [SRC_W-1:0] src;
		logic [DIV_W-1:0] div;
		logic ost_restart;
		logic sw_busy;
		logic core_rst_n;
		logic core_clk_en;
		logic osc_nrdy;
		logic [CLKOUT_DIV_W-1:0] clkdiv;
		logic pin_o;
		logic pin_oe_n;
		logic [1:0] gain;
		logic [1:0] epow;
		logic awrdy;
		logic wrdy;
		logic aw_got;
		logic w_got;
		logic [1:0] aw_idx;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arrdy;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} seq_state_t;

	seq_state_t s_q;
	seq_state_t s_d;

	logic por_bor;
	logic powerup_timer_done;
	logic ost_done;
	logic powerup_timer_ok;
	logic ost_ok;
	logic master_clear_pin_ok;
	logic ost_clear;
	logic clkin_rise;
	logic [31:0] status;
	logic [31:0] cfg_merged;

	// ======================================================================
	// decoding helpers
	function automatic logic is_crystal(input logic [SRC_W-1:0] src);
		is_crystal = (src == SRC_XTAL_LOW) || (src == SRC_XTAL_MED) ||
			(src == SRC_XTAL_HIGH);
	endfunction : is_crystal

	function automatic logic [1:0] reg_index(
		input logic [AXI_ADDR_W-1:0] addr
	);
		case (addr)
			OFS_CFG: reg_index = IDX_CFG;
			OFS_CLKSW: reg_index = IDX_CLKSW;
			OFS_STATUS: reg_index = IDX_STATUS;
			default: reg_index = IDX_NONE;
		endcase
	endfunction : reg_index

	function automatic logic [31:0] merge(
		input logic [31:0] old_w,
		input logic [31:0] new_w,
		input logic [3:0] strb
	);
		merge = old_w;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				merge[8*b +: 8] = new_w[8*b +: 8];
			end
		end
	endfunction : merge

	// ======================================================================
	// start-up timers
	// only power-on and brown-out restart the delay, master clear does not
	assign por_bor = POR_ACTIVE || BOR_ACTIVE;
	assign clkin_rise = CLOCK_IN_PIN && !s_q.clkin_q;
	assign ost_clear = por_bor || s_q.ost_restart;

	startup_count_timer #(
		.WIDTH(POWERUP_TIMER_W)
	) u_powerup_timer (
		.clk(CLK),
		.rst_n(RST_N),
		.ce(CE),
		.clear(por_bor),
		.tick(1'b1),
		.limit(POWERUP_TIMER_W'(POWERUP_TIMER_CYCLES)),
		.done(powerup_timer_done)
	);

	// counts oscillations seen on the clock input, not system cycles
	startup_count_timer #(
		.WIDTH(OST_W)
	) u_ost (
		.clk(CLK),
		.rst_n(RST_N),
		.ce(CE),
		.clear(ost_clear),
		.tick(clkin_rise),
		.limit(OST_W'(OST_OSC_COUNT)),
		.done(ost_done)
	);

	// gating conditions for leaving reset
	assign powerup_timer_ok = (s_q.cfg[CFG_POWERUP_DELAY_SELECT_LSB +: CFG_POWERUP_DELAY_SELECT_W] == '0) ||
		powerup_timer_done;
	// restart cycle masked so the stale done never leaks through
	assign ost_ok = !is_crystal(s_q.src) ||
		(ost_done && !s_q.ost_restart);
	assign master_clear_pin_ok = !s_q.cfg[CFG_MCLRE_BIT] || s_q.master_clear_pin_sync;

	// byte lanes of a pending configuration write merged over the old word
	assign cfg_merged = merge({16'h0000, s_q.cfg}, s_q.wdata, s_q.wstrb);

	// status word as software sees it
	always_comb begin
		status = '0;
		status[STAT_ST_LSB +: 4] = s_q.st;
		status[STAT_POWERUP_TIMER_BIT] = powerup_timer_ok;
		status[STAT_OST_BIT] = ost_ok;
		status[STAT_MASTER_CLEAR_PIN_BIT] = s_q.master_clear_pin_sync;
		status[STAT_BUSY_BIT] = s_q.sw_busy;
		status[STAT_SRC_LSB +: SRC_W] = s_q.src;
		status[STAT_DIV_LSB +: DIV_W] = s_q.div;
		status[STAT_PIN_BIT] = CLOCK_OUT_PIN_I;
	end

	// ======================================================================
	// next state
	always_comb begin
		s_d = s_q;
		s_d.ost_restart = 1'b0;

		// two-stage synchroniser, only the second stage is used
		s_d.master_clear_pin_meta = MASTER_CLEAR_PIN_N;
		s_d.master_clear_pin_sync = s_q.master_clear_pin_meta;
		s_d.clkin_q = CLOCK_IN_PIN;

		// bus write channels are taken independently, in any order
		if (AWVALID && s_q.awrdy) begin
			s_d.awrdy = 1'b0;
			s_d.aw_got = 1'b1;
			s_d.aw_idx = reg_index(AWADDR);
		end
		if (WVALID && s_q.wrdy) begin
			s_d.wrdy = 1'b0;
			s_d.w_got = 1'b1;
			s_d.wdata = WDATA;
			s_d.wstrb = WSTRB;
		end
		if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = RESP_OKAY;
			case (s_q.aw_idx)
				IDX_CFG: begin
					s_d.cfg = cfg_merged[15:0] & CFG_MASK;
				end
				IDX_CLKSW: begin
					// a run-time switch; a crystal restarts its count
					if (s_q.wstrb[0]) begin
						s_d.src = s_q.wdata[CSW_NEW_CLOCK_SOURCE_SELECT_LSB +: SRC_W];
						s_d.div = s_q.wdata[CSW_NEW_CLOCK_DIVIDER_LSB +: DIV_W];
						s_d.ost_restart = is_crystal(s_d.src);
						s_d.sw_busy = is_crystal(s_d.src);
					end
				end
				IDX_STATUS: begin
					s_d.bresp = RESP_OKAY;
				end
				default: begin
					s_d.bresp = RESP_SLVERR;
				end
			endcase
		end
		if (s_q.bvalid && BREADY) begin
			s_d.bvalid = 1'b0;
			s_d.awrdy = 1'b1;
			s_d.wrdy = 1'b1;
		end

		// bus read, answered the cycle after the address is taken
		if (ARVALID && s_q.arrdy) begin
			s_d.arrdy = 1'b0;
			s_d.rvalid = 1'b1;
			s_d.rresp = RESP_OKAY;
			case (reg_index(ARADDR))
				IDX_CFG: s_d.rdata = {16'h0000, s_q.cfg};
				IDX_CLKSW: s_d.rdata = {24'h000000, s_q.div, 1'b0, s_q.src};
				IDX_STATUS: s_d.rdata = status;
				default: begin
					s_d.rdata = 32'h00000000;
					s_d.rresp = RESP_SLVERR;
				end
			endcase
		end
		if (s_q.rvalid && RREADY) begin
			s_d.rvalid = 1'b0;
			s_d.arrdy = 1'b1;
		end

		// switch busy clears once the crystal count is through
		if (ost_ok && !s_d.ost_restart) begin
			s_d.sw_busy = 1'b0;
		end

		// wake from sleep re-arms the crystal count only
		if (WAKE && s_q.st == ST_RUN && is_crystal(s_q.src)) begin
			s_d.ost_restart = 1'b1;
		end

		// start-up sequence
		case (s_q.st)
			ST_HOLD: begin
				if (!por_bor) begin
					s_d.st = ST_WAIT;
				end
			end
			ST_WAIT: begin
				// timers keep running here whatever the pin does
				if (powerup_timer_ok && ost_ok && master_clear_pin_ok) begin
					s_d.st = ST_DELAY;
					s_d.dly_cnt = 4'h1;
				end
			end
			ST_DELAY: begin
				if (!master_clear_pin_ok) begin
					s_d.st = ST_WAIT;
				end else if (s_q.dly_cnt == MASTER_CLEAR_PIN_RELEASE_CYCLES - 4'h1) begin
					s_d.st = ST_RUN;
				end else begin
					s_d.dly_cnt = s_q.dly_cnt + 4'h1;
				end
			end
			ST_RUN: begin
				// master clear reset reloads the reset clock choice
				if (!master_clear_pin_ok) begin
					s_d.st = ST_WAIT;
					s_d.src = s_q.cfg[CFG_RCSS_LSB +: SRC_W];
					s_d.div = '0;
				end
			end
			default: begin
				s_d.st = ST_HOLD;
			end
		endcase

		// power-on or brown-out overrides the sequence state, clock choice and switch busy
		if (por_bor) begin
			s_d.st = ST_HOLD;
			s_d.src = s_q.cfg[CFG_RCSS_LSB +: SRC_W];
			s_d.div = '0;
			s_d.sw_busy = 1'b0;
		end

		// registered outputs
		s_d.core_rst_n = (s_d.st == ST_RUN);
		s_d.core_clk_en = ost_ok && (s_q.st != ST_HOLD);
		s_d.osc_nrdy = !ost_ok;
		s_d.gain = LVL_OFF;
		s_d.epow = LVL_OFF;
		case (s_d.src)
			SRC_XTAL_LOW: s_d.gain = LVL_LOW;
			SRC_XTAL_MED: s_d.gain = LVL_MED;
			SRC_XTAL_HIGH: s_d.gain = LVL_HIGH;
			SRC_EXT_LOW: s_d.epow = LVL_LOW;
			SRC_EXT_MED: s_d.epow = LVL_MED;
			SRC_EXT_HIGH: s_d.epow = LVL_HIGH;
			default: s_d.gain = LVL_OFF;
		endcase

		// clock out pin: divided clock or software-driven GPIO
		s_d.clkdiv = s_q.clkdiv + CLKOUT_DIV_W'(1);
		s_d.pin_o = s_q.cfg[CFG_CLKOUT_BIT] ?
			s_d.clkdiv[CLKOUT_DIV_W-1] : s_q.cfg[CFG_GPIO_D_BIT];
		s_d.pin_oe_n = !(s_q.cfg[CFG_CLKOUT_BIT] ||
			s_q.cfg[CFG_GPIO_OE_BIT]);

		// synchronous reset, taken even while ce is low
		if (!RST_N) begin
			s_d = '0;
			s_d.st = ST_HOLD;
			s_d.cfg = CFG_RESET;
			s_d.src = CFG_RESET[CFG_RCSS_LSB +: SRC_W];
			s_d.pin_oe_n = 1'b1;
			s_d.awrdy = 1'b1;
			s_d.wrdy = 1'b1;
			s_d.arrdy = 1'b1;
		end
	end

	// ======================================================================
	// state register
	// ce low freezes every bit, so a halted clock resumes exactly
	always_ff @(posedge CLK) begin
		if (!RST_N || CE) begin
			s_q <= s_d;
		end
	end

	// ======================================================================
	// outputs, all straight from the state register
	assign CORE_RESET_N = s_q.core_rst_n;
	assign CORE_CLK_EN = s_q.core_clk_en;
	assign OSC_NOT_READY = s_q.osc_nrdy;
	assign SYS_CLK_SRC = s_q.src;
	assign SYS_CLK_DIV = s_q.div;
	assign AMP_GAIN = s_q.gain;
	assign EXT_CLK_POWER = s_q.epow;
	assign CLOCK_OUT_PIN_O = s_q.pin_o;
	assign CLOCK_OUT_PIN_OE_N = s_q.pin_oe_n;
	assign AWREADY = s_q.awrdy;
	assign WREADY = s_q.wrdy;
	assign BVALID = s_q.bvalid;
	assign BRESP = s_q.bresp;
	assign ARREADY = s_q.arrdy;
	assign RVALID = s_q.rvalid;
	assign RDATA = s_q.rdata;
	assign RRESP = s_q.rresp;

endmodule : startup_reset_clock_sequencer

// ==== test/startup_osc_model.sv ====
`timescale 1ns/1ps
// ==========
// oscillator and clock-out pin model
module startup_osc_model (
	input wire logic clk,
	input wire logic run,
	input wire logic oe_n,
	input wire logic o,
	output logic osc,
	output logic pin
);
	// 20 MHz keeps the fast limits; slow modes run above rating for speed
	localparam int HALF = 5;
	int cnt_q = 0;
	logic last_q = 1'b0;

	// oscillation stands low while not running
	initial osc = 1'b0;
	always @(posedge clk) begin
		if (!run) begin
			cnt_q <= 0;
			osc <= 1'b0;
		end else if (cnt_q == HALF - 1) begin
			cnt_q <= 0;
			osc <= ~osc;
		end else begin
			cnt_q <= cnt_q + 1;
		end
	end

	// a released pin shows the inverse of its last driven level
	always @(posedge clk) begin
		if (!oe_n)
			last_q <= o;
	end
	assign pin = oe_n ? ~last_q : o;
endmodule : startup_osc_model

// ==== test/startup_seq_checker.sv ====
`timescale 1ns/1ps
// ==========
// port checker of the start-up sequencer
module startup_seq_checker (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CE,
	input wire logic POR_ACTIVE,
	input wire logic BOR_ACTIVE,
	input wire logic MASTER_CLEAR_PIN_N,
	input wire logic CLOCK_IN_PIN,
	input wire logic CORE_RESET_N,
	input wire logic CORE_CLK_EN,
	input wire logic OSC_NOT_READY,
	input wire logic [startup_seq_pkg::SRC_W-1:0] SYS_CLK_SRC,
	input wire logic [1:0] AMP_GAIN,
	input wire logic [1:0] EXT_CLK_POWER,
	input wire logic BVALID,
	input wire logic BREADY,
	input wire logic [1:0] BRESP
);
	import startup_seq_pkg::*;
	default clocking @(posedge CLK);
	endclocking
	default disable iff (!RST_N);

	// oscillations seen while the start-up timer runs, saturating
	logic pin_q;
	logic [11:0] rise_q;
	always_ff @(posedge CLK) begin
		pin_q <= CLOCK_IN_PIN;
		if (!OSC_NOT_READY)
			rise_q <= 12'h000;
		else if (CE && CLOCK_IN_PIN && !pin_q && !rise_q[11])
			rise_q <= rise_q + 12'h001;
	end

	sequence s_pin_low;
		CE && !MASTER_CLEAR_PIN_N ##1 CE ##1 CE;
	endsequence
	property p_por;
		CE && (POR_ACTIVE || BOR_ACTIVE) |=> !CORE_RESET_N;
	endproperty
	property p_pin;
		s_pin_low |-> ##[1:2] !CORE_RESET_N;
	endproperty
	// a short sync slack is allowed behind the ten-cycle count
	property p_rel;
		$rose(CORE_RESET_N) |-> $past(MASTER_CLEAR_PIN_N, 12);
	endproperty
	property p_gate;
		OSC_NOT_READY |-> !CORE_CLK_EN;
	endproperty
	property p_ext;
		SYS_CLK_SRC <= SRC_EXT_LOW |-> !OSC_NOT_READY;
	endproperty
	property p_gain;
		AMP_GAIN == ((SYS_CLK_SRC inside {[SRC_XTAL_LOW:SRC_XTAL_HIGH]}) ?
			2'(SYS_CLK_SRC - 3'h2) : LVL_OFF);
	endproperty
	property p_pwr;
		EXT_CLK_POWER == ((SYS_CLK_SRC <= SRC_EXT_LOW) ?
			2'(3'h3 - SYS_CLK_SRC) : LVL_OFF);
	endproperty
	property p_ost;
		$fell(OSC_NOT_READY) |-> rise_q >= 12'h3FE;
	endproperty
	property p_bhold;
		BVALID && !BREADY |=> BVALID && $stable(BRESP);
	endproperty
	property p_frz;
		!CE |=> $stable(CORE_RESET_N) && $stable(SYS_CLK_SRC)
			&& $stable(OSC_NOT_READY);
	endproperty

	a_por: assert property (p_por) else $error("left reset in hold");
	a_pin: assert property (p_pin) else $error("pin low ignored");
	a_rel: assert property (p_rel) else $error("ran too soon");
	a_gate: assert property (p_gate) else $error("clock not gated");
	a_ext: assert property (p_ext) else $error("ext timer on");
	a_gain: assert property (p_gain) else $error("bad gain");
	a_pwr: assert property (p_pwr) else $error("bad power");
	a_ost: assert property (p_ost) else $error("osc count short");
	a_bhold: assert property (p_bhold) else $error("bresp dropped");
	a_frz: assert property (p_frz) else $error("moved when stopped");
endmodule : startup_seq_checker

bind startup_reset_clock_sequencer startup_seq_checker i_startup_seq_checker (
	.CLK, .RST_N, .CE, .POR_ACTIVE, .BOR_ACTIVE, .MASTER_CLEAR_PIN_N,
	.CLOCK_IN_PIN, .CORE_RESET_N, .CORE_CLK_EN, .OSC_NOT_READY,
	.SYS_CLK_SRC, .AMP_GAIN, .EXT_CLK_POWER, .BVALID, .BREADY, .BRESP);

// ==== test/startup_reset_clock_sequencer_bench.sv ====
`timescale 1ns/1ps
module startup_reset_clock_sequencer_bench;
	import startup_seq_pkg::*;
	localparam int unsigned PW = 50;
	logic CLK, RST_N, CE, POR_ACTIVE, BOR_ACTIVE, MASTER_CLEAR_PIN_N, WAKE;
	logic CLOCK_IN_PIN, CLOCK_OUT_PIN_I, CLOCK_OUT_PIN_O, CLOCK_OUT_PIN_OE_N;
	logic CORE_RESET_N, CORE_CLK_EN, OSC_NOT_READY, osc_run, pv;
	logic [2:0] SYS_CLK_SRC, s;
	logic [3:0] SYS_CLK_DIV, WSTRB, AWADDR, ARADDR, dv;
	logic [1:0] AMP_GAIN, EXT_CLK_POWER, BRESP, RRESP, rr;
	logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
	logic ARVALID, ARREADY, RVALID, RREADY;
	logic [31:0] WDATA, RDATA, rs, rd;
	int fail_count, checked, cyc, n, k, j;

	startup_reset_clock_sequencer #(.POWERUP_TIMER_CYCLES(PW))
	i_startup_reset_clock_sequencer (.CLK, .RST_N, .CE, .POR_ACTIVE,
		.BOR_ACTIVE, .MASTER_CLEAR_PIN_N, .CLOCK_IN_PIN, .WAKE,
		.CLOCK_OUT_PIN_I, .CLOCK_OUT_PIN_O, .CLOCK_OUT_PIN_OE_N,
		.CORE_RESET_N, .CORE_CLK_EN, .OSC_NOT_READY, .SYS_CLK_SRC,
		.SYS_CLK_DIV, .AMP_GAIN, .EXT_CLK_POWER, .AWADDR, .AWVALID, .AWREADY,
		.WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR,
		.ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY);
	startup_osc_model i_startup_osc_model (.clk(CLK), .run(osc_run),
		.oe_n(CLOCK_OUT_PIN_OE_N), .o(CLOCK_OUT_PIN_O), .osc(CLOCK_IN_PIN),
		.pin(CLOCK_OUT_PIN_I));

	initial begin
		CLK = 1'b0;
		forever #2.5 CLK = ~CLK;
	end

	// ==========
	// helpers
	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction : rnd
	// gain over power expected for a source
	function automatic logic [3:0] lvl(input logic [2:0] c);
		if (c >= SRC_XTAL_LOW && c <= SRC_XTAL_HIGH)
			return {2'(c - 3'h2), LVL_OFF};
		return {LVL_OFF, (c <= SRC_EXT_LOW) ? 2'(3'h3 - c) : LVL_OFF};
	endfunction : lvl
	task automatic chk(input string nm, input logic [31:0] e, g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic ok(input string nm, input logic c);
		chk(nm, 32'h1, {31'h0, c});
	endtask : ok
	task automatic wrap_up();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up
	// bready is raised only once bvalid is seen, so bresp must stand
	task automatic axw(input logic [3:0] a, input logic [31:0] d);
		logic aw, wd;
		{aw, wd} = 2'h0;
		AWADDR <= a;
		WDATA <= d;
		{AWVALID, WVALID} <= 2'h3;
		while (!(aw && wd)) begin
			@(posedge CLK);
			if (AWVALID && AWREADY) begin
				aw = 1'b1;
				AWVALID <= 1'b0;
			end
			if (WVALID && WREADY) begin
				wd = 1'b1;
				WVALID <= 1'b0;
			end
		end
		do @(posedge CLK); while (BVALID !== 1'b1);
		BREADY <= 1'b1;
		@(posedge CLK);
		BREADY <= 1'b0;
	endtask : axw
	task automatic axr(input logic [3:0] a);
		ARADDR <= a;
		ARVALID <= 1'b1;
		do @(posedge CLK); while (ARREADY !== 1'b1);
		ARVALID <= 1'b0;
		RREADY <= 1'b1;
		do @(posedge CLK); while (RVALID !== 1'b1);
		rd = RDATA;
		rr = RRESP;
		RREADY <= 1'b0;
	endtask : axr
	// edges until the core leaves reset
	task automatic wait_run();
		n = 0;
		while (CORE_RESET_N !== 1'b1) begin
			@(posedge CLK);
			n++;
		end
	endtask : wait_run
	task automatic pulse(input logic b);
		{POR_ACTIVE, BOR_ACTIVE} <= {b, !b};
		repeat (3) @(posedge CLK);
		{POR_ACTIVE, BOR_ACTIVE} <= 2'h0;
	endtask : pulse

	// the ceiling covers about 40000 cycles of tests with margin
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			fail_count++;
			wrap_up();
		end
	end

	// ==========
	// tests
	initial begin
		{RST_N, CE, BOR_ACTIVE, WAKE, osc_run} = 5'h08;
		{POR_ACTIVE, MASTER_CLEAR_PIN_N} = 2'h3;
		{AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
		{AWADDR, ARADDR, WSTRB, WDATA} = {8'h00, 4'hF, 32'h0};
		rs = 32'h00004D56;
		{fail_count, checked, cyc} = {32'h0, 32'h0, 32'h0};
		repeat (10) @(posedge CLK);
		RST_N <= 1'b1;
		axr(OFS_CFG);
		chk("cfg_reset", {16'h0, CFG_RESET}, rd);
		POR_ACTIVE <= 1'b0;
		wait_run();
		ok("powerup_timer", n >= PW && n <= PW + 14);
		$display("done delay");
		MASTER_CLEAR_PIN_N <= 1'b0;
		pulse(1'b1);
		repeat (PW + 30) @(posedge CLK);
		ok("held", !CORE_RESET_N);
		MASTER_CLEAR_PIN_N <= 1'b1;
		wait_run();
		ok("release", n >= 11 && n <= 14);
		$display("done pin");
		axw(OFS_CFG, 32'h0000_0058);
		pulse(1'b0);
		wait_run();
		ok("bypass", n < PW / 2);
		MASTER_CLEAR_PIN_N <= 1'b0;
		repeat (5) @(posedge CLK);
		ok("pin_rst", !CORE_RESET_N);
		MASTER_CLEAR_PIN_N <= 1'b1;
		wait_run();
		ok("rerun", n <= 14);
		$display("done bypass");
		osc_run <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			s = 3'(i);
			dv = 4'(rnd());
			axw(OFS_CLKSW, {24'h0, dv, 1'b0, s});
			axr(OFS_CLKSW);
			chk("clksw", {24'h0, dv, 1'b0, s}, rd);
			chk("src", {25'h0, s, dv}, {25'h0, SYS_CLK_SRC, SYS_CLK_DIV});
			chk("lvl", {28'h0, lvl(s)}, {28'h0, AMP_GAIN, EXT_CLK_POWER});
			if (s >= SRC_XTAL_LOW) begin
				ok("gated", OSC_NOT_READY && !CORE_CLK_EN);
				{k, j} = {32'h0, 32'h0};
				pv = CLOCK_IN_PIN;
				while (OSC_NOT_READY) begin
					@(posedge CLK);
					j++;
					k += int'(CLOCK_IN_PIN && !pv);
					pv = CLOCK_IN_PIN;
					if (i == 4 && j == 2000) begin
						CE <= 1'b0;
						repeat (20) @(posedge CLK);
						CE <= 1'b1;
					end
				end
				// a few rises pass during the bus cycles before counting
				ok("osc_n", k >= 1020);
			end else
				ok("no_ost", !OSC_NOT_READY && CORE_CLK_EN);
		end
		// wake from sleep on a crystal source re-arms the count
		WAKE <= 1'b1;
		@(posedge CLK);
		WAKE <= 1'b0;
		repeat (2) @(posedge CLK);
		ok("wake", OSC_NOT_READY && !CORE_CLK_EN);
		do @(posedge CLK); while (OSC_NOT_READY !== 1'b0);
		@(posedge CLK);
		ok("wake_done", CORE_CLK_EN && CORE_RESET_N);
		$display("done sources");
		axw(OFS_CFG, 32'h0000_01D9);
		ok("gpio", CLOCK_OUT_PIN_O && !CLOCK_OUT_PIN_OE_N);
		axw(OFS_CFG, 32'h0000_0079);
		pv = CLOCK_OUT_PIN_O;
		k = 0;
		repeat (8) begin
			@(posedge CLK);
			k += int'(CLOCK_OUT_PIN_O !== pv);
			pv = CLOCK_OUT_PIN_O;
		end
		ok("clkout", !CLOCK_OUT_PIN_OE_N && k >= 3 && k <= 4);
		axr(OFS_STATUS);
		chk("state", {28'h0, ST_RUN}, {28'h0, rd[3:0]});
		axr(4'hC);
		chk("unmap", {30'h0, RESP_SLVERR}, {30'h0, rr});
		chk("unmap_d", 32'h0, rd);
		$display("done pins and bus");
		wrap_up();
	end
endmodule : startup_reset_clock_sequencer_bench
